// file: rtl/alc_pkg.sv
package alc_pkg;
    localparam int ALC_LINES = 16;
    localparam int ALC_SECS = 16;
    // Register indices on the plain register port
    localparam logic [3:0] OFF_LCW = 4'h0;
    localparam logic [3:0] OFF_SEL = 4'h1;
    localparam logic [3:0] OFF_EXT = 4'h2;
    localparam logic [3:0] OFF_LST = 4'h3;
    // Control word field positions
    localparam int LCW_EXT_LO = 4;
    localparam int LCW_CODE_LO = 9;
    localparam int LCW_PAY_LO = 11;
    localparam int LCW_STROBE = 15;
    // Select register field positions
    localparam int SEL_LINE_LO = 0;
    localparam int SEL_SEC_LO = 8;
    // Line state bits
    localparam int LST_ACTIVE = 0;
    localparam int LST_RESYNC = 1;
    // Primary and format register bits within the payload
    localparam int PRI_HALF = 0;
    localparam int PRI_EVEN = 1;
    localparam int PRI_RXEN = 2;
    localparam int PRI_BREAK = 3;
    localparam int FMT_PAREN = 3;
    // Register selection codes, bit 10 then bit 9
    localparam logic [1:0] CODE_PRI = 2'h0;
    localparam logic [1:0] CODE_FMT = 2'h1;
    localparam logic [1:0] CODE_BAUD = 2'h2;
    localparam logic [1:0] CODE_MNT = 2'h3;
    // Reset values
    localparam logic [3:0] RST_CFG = 4'h0;
    localparam logic [1:0] RST_CODE = 2'h0;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic LVL_MARK = 1'b1;
    localparam logic LVL_SPACE = 1'b0;
endpackage : alc_pkg

// file: rtl/alc_cfg_if.sv
`timescale 1ns/1ps
interface alc_cfg_if #(parameter int NL = 16);
    logic load;
    logic [3:0] line;
    logic [1:0] code;
    logic [3:0] pay;
    logic [NL-1:0][3:0] pri;
    logic [NL-1:0][3:0] fmt;
    logic [NL-1:0][3:0] baud;
    logic [NL-1:0][3:0] mnt;
    modport host (output load, line, code, pay,
        input pri, fmt, baud, mnt);
    modport store (input load, line, code, pay,
        output pri, fmt, baud, mnt);
endinterface : alc_cfg_if

// file: rtl/alc_cfg_store.sv
`timescale 1ns/1ps
module alc_cfg_store
    import alc_pkg::*;
#(
    parameter int NL = ALC_LINES
) (
    input wire logic mclk,
    input wire logic srst,
    alc_cfg_if.store cfg
);
    typedef struct packed {
        logic [NL-1:0][3:0] pri;
        logic [NL-1:0][3:0] fmt;
        logic [NL-1:0][3:0] baud;
        logic [NL-1:0][3:0] mnt;
    } alc_store_t;

    alc_store_t st;
    alc_store_t next_st;

    always_comb begin
        next_st = st;
        if (cfg.load && (int'(cfg.line) < NL)) begin
            case (cfg.code)
                CODE_PRI: next_st.pri[cfg.line] = cfg.pay;
                CODE_FMT: next_st.fmt[cfg.line] = cfg.pay;
                CODE_BAUD: next_st.baud[cfg.line] = cfg.pay;
                CODE_MNT: next_st.mnt[cfg.line] = cfg.pay;
                default: next_st = st;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st <= '{default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign cfg.pri = st.pri;
    assign cfg.fmt = st.fmt;
    assign cfg.baud = st.baud;
    assign cfg.mnt = st.mnt;

    a_store_primary: assert property (@(posedge mclk) disable iff (srst)
        cfg.load && cfg.code == CODE_PRI
        |=> st.pri[$past(cfg.line)] == $past(cfg.pay))
        else $error("primary register not loaded");
    a_store_format: assert property (@(posedge mclk) disable iff (srst)
        cfg.load && cfg.code == CODE_FMT
        |=> st.fmt[$past(cfg.line)] == $past(cfg.pay))
        else $error("format register not loaded");
endmodule : alc_cfg_store

// file: rtl/alc_line_port.sv
`timescale 1ns/1ps
module alc_line_port
    import alc_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [3:0] pri,
    input wire logic [3:0] fmt,
    input wire logic tx_data,
    input wire logic tx_busy,
    input wire logic rx_in,
    output logic line_out,
    output logic rx_data,
    output logic par_even,
    output logic par_en
);
    typedef struct packed {
        logic line_out;
        logic rx_data;
        logic par_even;
        logic par_en;
    } alc_port_t;

    alc_port_t st;
    alc_port_t next_st;

    always_comb begin
        next_st = st;
        // Transmitter keeps its timing; break only masks the pin
        next_st.line_out = pri[PRI_BREAK] ? LVL_SPACE : tx_data;
        if (pri[PRI_RXEN] && !(pri[PRI_HALF] && tx_busy)) begin
            next_st.rx_data = rx_in;
        end else begin
            next_st.rx_data = LVL_MARK;
        end
        next_st.par_even = pri[PRI_EVEN];
        next_st.par_en = fmt[FMT_PAREN];
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st <= '{LVL_MARK, LVL_MARK, 1'b0, 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign line_out = st.line_out;
    assign rx_data = st.rx_data;
    assign par_even = st.par_even;
    assign par_en = st.par_en;

    a_break_space: assert property (@(posedge mclk) disable iff (srst)
        pri[PRI_BREAK] |=> line_out == LVL_SPACE)
        else $error("break did not force space");
    a_half_blind: assert property (@(posedge mclk) disable iff (srst)
        pri[PRI_HALF] && tx_busy |=> rx_data == LVL_MARK)
        else $error("receiver not blinded in half duplex");
endmodule : alc_line_port

// file: rtl/alc_top.sv
// Overview of operation
// - Control word read shows bits 16,17 of selected address register in 4,5.
// - Code in bits 9,10 and selected line choose the strobe target.
// - Register selection code clears on Initialize.
// - Four 4-bit registers per line, loaded from bits 11-14 on strobe.
// - Initialize clears every per-line configuration register.
// - Bit 15 written one copies payload, then reads back as zero.
// - Strobe takes payload and code from the same write.
// - Code 00 targets the primary register.
// - Primary bit 11 set means half duplex, clear full duplex.
// - Half duplex receiver ignores input while its line transmits.
// - Primary bit 12 selects even parity, clear odd, when enabled.
// - Receiver runs only with bit 13 set; active flag then sets.
// - Primary bit 14 holds line output at space for break.
// - Break characters keep normal timing but never reach the line.
// - Code with bit 9 one, bit 10 zero targets format register.
// - Code with bit 9 zero, bit 10 one targets baud register.
// - Parity sense comes from primary bit 12 of the same line.
`timescale 1ns/1ps
module alc_top
    import alc_pkg::*;
#(
    parameter int NL = ALC_LINES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic [NL-1:0] tx_data,
    input wire logic [NL-1:0] tx_busy,
    input wire logic [NL-1:0] rx_in,
    output logic [NL-1:0] line_out,
    output logic [NL-1:0] rx_data,
    output logic [NL-1:0] rx_active,
    output logic [NL-1:0] half_duplex,
    output logic [NL-1:0] par_even,
    output logic [NL-1:0] par_en,
    output logic [NL-1:0][1:0] char_len,
    output logic [NL-1:0] two_stop,
    output logic [NL-1:0][3:0] speed_code,
    output logic [NL-1:0][3:0] maint_code
);
    typedef struct packed {
        logic [1:0] code;
        logic [3:0] pay;
        logic [3:0] sel_line;
        logic [3:0] sel_sec;
        logic [NL-1:0][ALC_SECS-1:0][1:0] ext;
        logic [NL-1:0] active;
        logic [NL-1:0] resync;
        logic [15:0] rdata;
    } alc_top_t;

    alc_top_t st;
    alc_top_t next_st;

    alc_cfg_if #(.NL(NL)) cfg ();

    logic wr_lcw;
    logic wr_sel;
    logic wr_ext;
    logic wr_lst;
    logic [1:0] ext_sel;
    logic [1:0] lst_sel;
    logic [3:0] wr_code4;

    assign wr_lcw = wr && (addr == OFF_LCW);
    assign wr_sel = wr && (addr == OFF_SEL);
    assign wr_ext = wr && (addr == OFF_EXT);
    assign wr_lst = wr && (addr == OFF_LST);
    assign wr_code4 = {2'h0, wdata[LCW_CODE_LO +: 2]};

    // Strobe acts on the write data itself, not the held fields
    assign cfg.load = wr_lcw && wdata[LCW_STROBE];
    assign cfg.line = st.sel_line;
    assign cfg.code = wdata[LCW_CODE_LO +: 2];
    assign cfg.pay = wdata[LCW_PAY_LO +: 4];

    alc_cfg_store #(
        .NL(NL)
    ) i_alc_cfg_store (
        .mclk(mclk),
        .srst(srst),
        .cfg(cfg)
    );

    genvar gl;
    generate
        for (gl = 0; gl < NL; gl++) begin : g_line
            alc_line_port i_alc_line_port (
                .mclk(mclk),
                .srst(srst),
                .pri(cfg.pri[gl]),
                .fmt(cfg.fmt[gl]),
                .tx_data(tx_data[gl]),
                .tx_busy(tx_busy[gl]),
                .rx_in(rx_in[gl]),
                .line_out(line_out[gl]),
                .rx_data(rx_data[gl]),
                .par_even(par_even[gl]),
                .par_en(par_en[gl])
            );
            assign half_duplex[gl] = cfg.pri[gl][PRI_HALF];
            assign char_len[gl] = cfg.fmt[gl][1:0];
            assign two_stop[gl] = cfg.fmt[gl][2];
            assign speed_code[gl] = cfg.baud[gl];
            assign maint_code[gl] = cfg.mnt[gl];
        end
    endgenerate

    assign ext_sel = st.ext[st.sel_line][st.sel_sec];
    assign lst_sel = {st.resync[st.sel_line], st.active[st.sel_line]};

    always_comb begin
        next_st = st;
        next_st.rdata = RST_WORD;

        // Held selection and payload fields
        if (wr_lcw) begin
            next_st.code = wdata[LCW_CODE_LO +: 2];
            next_st.pay = wdata[LCW_PAY_LO +: 4];
        end
        if (wr_sel) begin
            next_st.sel_line = wdata[SEL_LINE_LO +: 4];
            next_st.sel_sec = wdata[SEL_SEC_LO +: 4];
        end
        if (wr_ext) begin
            next_st.ext[st.sel_line][st.sel_sec] = wdata[1:0];
        end

        // Receiver state per line; hardware set wins over resync clear
        for (int i = 0; i < NL; i++) begin
            if (wr_lst && (int'(st.sel_line) == i)
                && wdata[LST_RESYNC]) begin
                next_st.resync[i] = 1'b1;
            end
            if (st.resync[i] && !cfg.pri[i][PRI_RXEN]) begin
                next_st.active[i] = 1'b0;
            end
            if (cfg.pri[i][PRI_RXEN] && !st.active[i]) begin
                next_st.active[i] = 1'b1;
                next_st.resync[i] = 1'b0;
            end
        end

        // Read data stand only in the cycle after the read strobe
        if (rd) begin
            case (addr)
                OFF_LCW: begin
                    next_st.rdata[LCW_EXT_LO +: 2] = ext_sel;
                end
                OFF_SEL: begin
                    next_st.rdata[SEL_LINE_LO +: 4] = st.sel_line;
                    next_st.rdata[SEL_SEC_LO +: 4] = st.sel_sec;
                end
                OFF_EXT: begin
                    next_st.rdata[1:0] = ext_sel;
                end
                OFF_LST: begin
                    next_st.rdata[1:0] = lst_sel;
                end
                default: begin
                    next_st.rdata = RST_WORD;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st <= '{default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign rx_active = st.active;

    a_code_reset: assert property (@(posedge mclk)
        srst |=> st.code == RST_CODE)
        else $error("selection code not cleared by reset");

    a_lcw_ext_read: assert property (@(posedge mclk) disable iff (srst)
        rd && addr == OFF_LCW && !wr_ext
        |=> rdata[LCW_EXT_LO +: 2] == $past(ext_sel))
        else $error("extended address bits wrong on read");

    a_lcw_zero_bits: assert property (@(posedge mclk) disable iff (srst)
        rd && addr == OFF_LCW
        |=> rdata[15:6] == 10'h000 && rdata[3:0] == 4'h0)
        else $error("unused control word bits not zero");

    a_strobe_clear: assert property (@(posedge mclk) disable iff (srst)
        rd && addr == OFF_LCW |=> !rdata[LCW_STROBE])
        else $error("strobe bit did not clear itself");

    a_no_strobe_hold: assert property (@(posedge mclk) disable iff (srst)
        wr_lcw && !wdata[LCW_STROBE]
        |=> $stable(cfg.pri) && $stable(cfg.fmt)
            && $stable(cfg.baud) && $stable(cfg.mnt))
        else $error("register changed without strobe");

    a_same_write: assert property (@(posedge mclk) disable iff (srst)
        wr_lcw && wdata[LCW_STROBE] && wr_code4 == 4'h0
        |=> cfg.pri[$past(st.sel_line)]
            == $past(wdata[LCW_PAY_LO +: 4]))
        else $error("strobe did not use its own write data");

    a_baud_target: assert property (@(posedge mclk) disable iff (srst)
        cfg.load && cfg.code == CODE_BAUD
        |=> cfg.baud[$past(cfg.line)] == $past(cfg.pay)
            && $stable(cfg.pri))
        else $error("baud code loaded wrong register");

    a_rx_active_set: assert property (@(posedge mclk) disable iff (srst)
        cfg.pri[0][PRI_RXEN] ##1 cfg.pri[0][PRI_RXEN] |-> rx_active[0])
        else $error("receiver active not set after enable");

    a_read_once: assert property (@(posedge mclk) disable iff (srst)
        !rd |=> rdata == RST_WORD)
        else $error("read data stood outside read cycle");

    a_lst_read: assert property (@(posedge mclk) disable iff (srst)
        rd && addr == OFF_LST |=> rdata[1:0] == $past(lst_sel))
        else $error("line state read wrong");

    a_parity_src: assert property (@(posedge mclk) disable iff (srst)
        1'b1 |=> par_even[0] == $past(cfg.pri[0][PRI_EVEN]))
        else $error("parity sense not from primary register");

    a_break_line: assert property (@(posedge mclk) disable iff (srst)
        cfg.pri[0][PRI_BREAK] ##1 cfg.pri[0][PRI_BREAK]
        |-> line_out[0] == LVL_SPACE)
        else $error("character reached line during break");

    a_sel_read: assert property (@(posedge mclk) disable iff (srst)
        rd && addr == OFF_SEL
        |=> rdata[SEL_LINE_LO +: 4] == $past(st.sel_line)
            && rdata[SEL_SEC_LO +: 4] == $past(st.sel_sec))
        else $error("select register read wrong");

    a_ext_read: assert property (@(posedge mclk) disable iff (srst)
        rd && addr == OFF_EXT |=> rdata == {14'h0000, $past(ext_sel)})
        else $error("extended address store read wrong");

    a_ext_write: assert property (@(posedge mclk) disable iff (srst)
        wr_ext
        |=> st.ext[$past(st.sel_line)][$past(st.sel_sec)]
            == $past(wdata[1:0]))
        else $error("extended address bits not stored");

    a_sel_write: assert property (@(posedge mclk) disable iff (srst)
        wr_sel
        |=> st.sel_line == $past(wdata[SEL_LINE_LO +: 4])
            && st.sel_sec == $past(wdata[SEL_SEC_LO +: 4]))
        else $error("select fields not stored");

    a_code_hold: assert property (@(posedge mclk) disable iff (srst)
        wr_lcw |=> st.code == $past(wdata[LCW_CODE_LO +: 2]))
        else $error("selection code not held");

    a_code_keep: assert property (@(posedge mclk) disable iff (srst)
        !wr_lcw |=> $stable(st.code))
        else $error("selection code changed without write");

    a_pay_hold: assert property (@(posedge mclk) disable iff (srst)
        wr_lcw |=> st.pay == $past(wdata[LCW_PAY_LO +: 4]))
        else $error("payload field not held");

    a_cfg_reset: assert property (@(posedge mclk)
        srst |=> cfg.pri == '0 && cfg.fmt == '0
            && cfg.baud == '0 && cfg.mnt == '0)
        else $error("line registers not cleared by reset");

    a_active_reset: assert property (@(posedge mclk)
        srst |=> rx_active == '0)
        else $error("receiver active not cleared by reset");

    a_rdata_reset: assert property (@(posedge mclk)
        srst |=> rdata == RST_WORD)
        else $error("read data not cleared by reset");

    a_lst_zero: assert property (@(posedge mclk) disable iff (srst)
        rd && addr == OFF_LST |=> rdata[15:2] == 14'h0000)
        else $error("unused line state bits not zero");

    a_pri_only: assert property (@(posedge mclk) disable iff (srst)
        cfg.load && cfg.code == CODE_PRI
        |=> $stable(cfg.fmt) && $stable(cfg.baud) && $stable(cfg.mnt))
        else $error("primary code touched another register");

    a_fmt_only: assert property (@(posedge mclk) disable iff (srst)
        cfg.load && cfg.code == CODE_FMT
        |=> $stable(cfg.pri) && $stable(cfg.baud) && $stable(cfg.mnt))
        else $error("format code touched another register");

    a_mnt_target: assert property (@(posedge mclk) disable iff (srst)
        cfg.load && cfg.code == CODE_MNT
        |=> cfg.mnt[$past(cfg.line)] == $past(cfg.pay)
            && $stable(cfg.pri) && $stable(cfg.fmt))
        else $error("maintenance code loaded wrong register");

    a_no_load_hold: assert property (@(posedge mclk) disable iff (srst)
        !cfg.load
        |=> $stable(cfg.pri) && $stable(cfg.fmt)
            && $stable(cfg.baud) && $stable(cfg.mnt))
        else $error("line register changed without strobe");

    a_active_clear: assert property (@(posedge mclk) disable iff (srst)
        st.resync[0] && !cfg.pri[0][PRI_RXEN] |=> !rx_active[0])
        else $error("receiver active not cleared by resync");

    a_resync_set: assert property (@(posedge mclk) disable iff (srst)
        wr_lst && wdata[LST_RESYNC]
        |=> st.resync[$past(st.sel_line)]
            || st.active[$past(st.sel_line)])
        else $error("resynchronize request lost");

    a_rx_off_mark: assert property (@(posedge mclk) disable iff (srst)
        !cfg.pri[0][PRI_RXEN] |=> rx_data[0] == LVL_MARK)
        else $error("disabled receiver passed input");

    a_full_follow: assert property (@(posedge mclk) disable iff (srst)
        !srst && cfg.pri[0][PRI_RXEN] && !cfg.pri[0][PRI_HALF]
        |=> rx_data[0] == $past(rx_in[0]))
        else $error("full duplex receiver input lost");

    a_line_follow: assert property (@(posedge mclk) disable iff (srst)
        !srst && !cfg.pri[0][PRI_BREAK]
        |=> line_out[0] == $past(tx_data[0]))
        else $error("transmitter bit did not reach line");

    a_par_en_src: assert property (@(posedge mclk) disable iff (srst)
        1'b1 |=> par_en[0] == $past(cfg.fmt[0][FMT_PAREN]))
        else $error("parity enable not from format register");
endmodule : alc_top

// file: verif/alc_line_far.sv
`timescale 1ns/1ps
module alc_line_far #(
    parameter int NL = 16,
    parameter logic [7:0] CHAR = 8'hA5
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [NL-1:0] send,
    output logic [NL-1:0] tx_data,
    output logic [NL-1:0] tx_busy,
    output logic [NL-1:0] rx_in
);
    // Frame of start, eight data, stop, then three idle cycles
    logic [3:0] cnt;
    logic [7:0] sh;
    logic bit_now;
    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt <= 4'h0;
            sh <= 8'h5A;
        end else begin
            cnt <= (cnt == 4'hC) ? 4'h0 : cnt + 4'h1;
            sh <= {sh[6:0], sh[7] ^ sh[5] ^ sh[4] ^ sh[3]};
        end
    end
    always_comb begin
        if (cnt == 4'h0) begin
            bit_now = 1'b0;
        end else if (cnt < 4'h9) begin
            bit_now = CHAR[cnt - 4'h1];
        end else begin
            bit_now = 1'b1;
        end
    end
    // Idle transmitters rest at mark; the remote terminal never stops
    assign tx_data = ~send | {NL{bit_now}};
    assign tx_busy = send & {NL{cnt < 4'hA}};
    assign rx_in = {NL{sh[0]}};
endmodule : alc_line_far

// file: verif/tb_alc_top.sv
`timescale 1ns/1ps
module tb_alc_top;
import alc_pkg::*;
localparam int NL = 16;
logic mclk, srst, wr, rd;
logic [3:0] addr;
logic [15:0] wdata, rdata, r;
logic [NL-1:0] tx_data, tx_busy, rx_in, send, line_out, rx_data, rx_active;
logic [NL-1:0] half_duplex, par_even, par_en, two_stop;
logic [NL-1:0][1:0] char_len;
logic [NL-1:0][3:0] speed_code, maint_code;
logic [3:0] p, e;
int n_fail = 0;
int tests_run = 0;
int lines[3] = '{0, 7, NL - 1};

alc_top #(.NL(NL)) i_alc_top (.mclk(mclk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_data(tx_data),
    .tx_busy(tx_busy), .rx_in(rx_in), .line_out(line_out),
    .rx_data(rx_data), .rx_active(rx_active), .half_duplex(half_duplex),
    .par_even(par_even), .par_en(par_en), .char_len(char_len),
    .two_stop(two_stop), .speed_code(speed_code), .maint_code(maint_code));
alc_line_far #(.NL(NL)) i_alc_line_far (.mclk(mclk), .srst(srst),
    .send(send), .tx_data(tx_data), .tx_busy(tx_busy), .rx_in(rx_in));

initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
end

task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
        $display("No errors found");
    end else begin
        $display("Errors were found");
    end
    $finish;
endtask : print_verdict

task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
        n_fail++;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask : chk

task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
endtask : wr_reg

task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
endtask : rd_reg

task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
endtask : settle

function automatic logic [15:0] cw(input logic [1:0] c, input logic [3:0] v,
    input logic s);
    return {s, v, c, 9'h000};
endfunction : cw

// Select the line, strobe the payload, let line port registers catch up
task automatic load(input int l, input logic [1:0] c, input logic [3:0] v);
    wr_reg(OFF_SEL, 16'(l));
    wr_reg(OFF_LCW, cw(c, v, 1'b1));
    settle(3);
endtask : load

function automatic logic [3:0] cfg_of(input int l, input logic [1:0] c);
    case (c)
        CODE_PRI: return {2'b00, par_even[l], half_duplex[l]};
        CODE_FMT: return {par_en[l], two_stop[l], char_len[l]};
        CODE_BAUD: return speed_code[l];
        default: return maint_code[l];
    endcase
endfunction : cfg_of

// Each cycle, line outputs must show the previous cycle's inputs
task automatic follow(input int l, input logic brk, input logic half,
    input logic en, input int n);
    logic td, tb, ri;
    repeat (n) begin
        @(negedge mclk);
        td = tx_data[l];
        tb = tx_busy[l];
        ri = rx_in[l];
        @(posedge mclk);
        #1;
        chk({15'h0000, line_out[l]}, {15'h0000, ~brk & td});
        chk({15'h0000, rx_data[l]}, {15'h0000, (en && !(half && tb)) ? ri
            : 1'b1});
    end
endtask : follow

initial begin
    #1000000;
    n_fail++;
    print_verdict;
end

initial begin
    srst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    send = '0;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    settle(1);
    rd_reg(OFF_LCW, r);
    chk(r, RST_WORD);
    chk(line_out, {NL{LVL_MARK}});
    chk({half_duplex | par_en}, 16'h0000);
    chk({speed_code[0], maint_code[NL-1], 4'(cfg_of(3, CODE_FMT)),
        4'h0}, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
        for (int c = 0; c < 4; c++) begin
            p = 4'(lines[i] + c + 1);
            e = (c == 0) ? {2'b00, p[1:0]} : p;
            load(lines[i], 2'(c), p);
            chk({12'h000, cfg_of(lines[i], 2'(c))}, {12'h000, e});
            wr_reg(OFF_LCW, cw(2'(c), ~p, 1'b0));
            settle(3);
            chk({12'h000, cfg_of(lines[i], 2'(c))}, {12'h000, e});
            rd_reg(OFF_LCW, r);
            chk(r, 16'h0000);
        end
    end
    $display("test strobe targets done");
    wr_reg(OFF_SEL, 16'h0302);
    wr_reg(OFF_EXT, 16'h0002);
    rd_reg(OFF_LCW, r);
    chk(r, 16'h0020);
    rd_reg(OFF_SEL, r);
    chk(r, 16'h0302);
    rd_reg(OFF_EXT, r);
    chk(r, 16'h0002);
    rd_reg(4'hF, r);
    chk(r, 16'h0000);
    $display("test readback done");
    @(posedge mclk);
    send <= 16'h0001;
    load(0, CODE_PRI, 4'hC);
    follow(0, 1'b1, 1'b0, 1'b1, 26);
    chk({15'h0000, rx_active[0]}, 16'h0001);
    load(0, CODE_PRI, 4'h5);
    follow(0, 1'b0, 1'b1, 1'b1, 26);
    load(0, CODE_PRI, 4'h4);
    follow(0, 1'b0, 1'b0, 1'b1, 13);
    $display("test break and duplex done");
    load(0, CODE_PRI, 4'h6);
    load(0, CODE_FMT, 4'h8);
    chk({14'h0000, par_en[0], par_even[0]}, 16'h0003);
    load(0, CODE_PRI, 4'h4);
    chk({14'h0000, par_en[0], par_even[0]}, 16'h0002);
    $display("test parity done");
    load(0, CODE_PRI, 4'h0);
    wr_reg(OFF_LST, 16'h0002);
    settle(2);
    chk({15'h0000, rx_active[0]}, 16'h0000);
    rd_reg(OFF_LST, r);
    chk(r, 16'h0002);
    follow(0, 1'b0, 1'b0, 1'b0, 4);
    repeat (13) @(posedge mclk);
    load(0, CODE_PRI, 4'h4);
    chk({15'h0000, rx_active[0]}, 16'h0001);
    rd_reg(OFF_LST, r);
    chk(r, 16'h0001);
    $display("test shutdown done");
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    settle(1);
    chk({speed_code[NL-1], maint_code[NL-1], 4'(cfg_of(NL - 1, CODE_FMT)),
        4'(cfg_of(0, CODE_PRI))}, 16'h0000);
    chk({15'h0000, rx_active[0]}, 16'h0000);
    rd_reg(OFF_LCW, r);
    chk(r, 16'h0000);
    $display("test second reset done");
    print_verdict;
end
endmodule : tb_alc_top
